// >>> hdl/sfp_flash_pins.sv
// serial flash target: pin framing, shifting and dual-lane read
// Contract
// - deselected: standby, output pin tri-stated
// - deselected: ignore serial input entirely
// - busy operation finishes before standby
// - sample input on rising clock
// - change output only on falling clock
// - single mode: opcode, address on input
// - dual read: input pin drives low lane
// - modes 0 and 3 both accepted
// - program carries 1 to 256 bytes
// - dual read: output pin drives high lane
`timescale 1ns/1ps
module sfp_flash_pins (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // link pins
  input  wire logic        sel_n,
  input  wire logic        sck,
  input  wire logic        dual_lane_low_in,
  output logic             dual_lane_low_out,
  output logic             dual_lane_low_oe,
  output logic             dual_lane_high_out,
  output logic             dual_lane_high_oe,
  // read data source
  input  wire logic [7:0]  rd_data,
  output logic [23:0]      rd_addr,
  // program data sink
  output logic [7:0]       wr_data,
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic [23:0]      wr_addr,
  // self-timed operation
  output logic             op_start,
  output logic [7:0]       op_code,
  input  wire logic        op_busy,
  output logic             standby
);
  logic [2:0] s_sel;
  logic [2:0] s_sck;
  logic [1:0] s_din;
  logic       sck_q;
  logic       active;
  logic       rise;
  logic       fall;
  logic       bit_in;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic [4:0] acnt;
  logic [7:0] opc;
  logic [7:0] obyte;
  logic       dual;
  logic [8:0] nbytes;
  logic       prog_pend;
  logic [2:0] obit;
  sfp_pkg::sfp_state_type st;

  sfp_fifo_if #(.width(sfp_pkg::byte_w)) fq ();

  sfp_fifo #(.width(sfp_pkg::byte_w), .depth(sfp_pkg::fifo_depth)) u_fifo (
    .clock  (clock),
    .arst_n (arst_n),
    .port   (fq.fifo)
  );

  // pins cross into the clock domain; only stage 2 onward is read
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_sel <= sfp_pkg::sync_rst;
      s_sck <= '0;
      s_din <= '0;
    end else begin
      s_sel <= {s_sel[1:0], sel_n};
      s_sck <= {s_sck[1:0], sck};
      s_din <= {s_din[0], dual_lane_low_in};
    end
  end

  assign active = !s_sel[1];
  assign bit_in = s_din[1];
  // edges found only while selected; idle level of the clock is irrelevant
  assign rise   = active && s_sck[1] && !s_sck[2];
  assign fall   = active && !s_sck[1] && s_sck[2];
  assign sck_q  = s_sck[1];

  function automatic logic is_read(input logic [7:0] c);
    is_read = (c == sfp_pkg::op_read) || (c == sfp_pkg::op_read_dual);
  endfunction

  function automatic logic is_prog(input logic [7:0] c);
    is_prog = (c == sfp_pkg::op_program) || (c == sfp_pkg::op_prog_dual);
  endfunction

  // command state; deselect always returns to idle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st     <= sfp_pkg::st_idle;
      shreg  <= '0;
      bitcnt <= '0;
      acnt   <= '0;
      opc    <= '0;
      rd_addr <= '0;
      nbytes <= '0;
    end else if (!active) begin
      st     <= sfp_pkg::st_idle;
      bitcnt <= '0;
    end else if (rise) begin
      shreg  <= {shreg[6:0], bit_in};
      bitcnt <= bitcnt + 3'h1;
      case (st)
        sfp_pkg::st_idle, sfp_pkg::st_cmd: begin
          st <= sfp_pkg::st_cmd;
          if (bitcnt == 3'h7) begin
            opc  <= {shreg[6:0], bit_in};
            acnt <= '0;
            st   <= sfp_pkg::st_addr;
          end
        end
        sfp_pkg::st_addr: begin
          rd_addr <= {rd_addr[22:0], bit_in};
          acnt    <= acnt + 5'h1;
          nbytes  <= '0;
          if (acnt == sfp_pkg::addr_bits - 5'h1) begin
            if (is_read(opc)) st <= sfp_pkg::st_rd;
            else if (is_prog(opc)) st <= sfp_pkg::st_wr;
            else st <= sfp_pkg::st_skip;
          end
        end
        sfp_pkg::st_wr: begin
          if (bitcnt == 3'h7 && nbytes != sfp_pkg::page_max) begin
            nbytes <= nbytes + 9'h1;
          end
        end
        sfp_pkg::st_rd, sfp_pkg::st_skip: begin
        end
        default: st <= sfp_pkg::st_idle;
      endcase
    end
  end

  // program bytes go through the fifo; extra bytes past a page are dropped
  assign fq.wdata  = {shreg[6:0], bit_in};
  assign fq.wvalid = rise && st == sfp_pkg::st_wr && bitcnt == 3'h7 && nbytes != sfp_pkg::page_max;
  // pop exactly when the output stage loads, else a stalled word would be sent twice
  assign fq.rready = !wr_valid || wr_ready;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_valid <= 1'b0;
      wr_data  <= '0;
    end else if (!wr_valid || wr_ready) begin
      wr_valid <= fq.rvalid;
      wr_data  <= fq.rdata;
    end
  end

  // self-timed start on deselect after an erase, or after a program with at least one byte
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prog_pend <= 1'b0;
      op_start  <= 1'b0;
      op_code   <= '0;
      wr_addr   <= '0;
    end else begin
      op_start <= 1'b0;
      if (active && st == sfp_pkg::st_addr) begin
        prog_pend <= 1'b0;
      end else if (active && ((st == sfp_pkg::st_wr && nbytes != '0) ||
                             (st == sfp_pkg::st_skip && opc == sfp_pkg::op_erase))) begin
        prog_pend <= 1'b1;
      end else if (!active && prog_pend) begin
        prog_pend <= 1'b0;
        op_start  <= 1'b1;
        op_code   <= opc;
        wr_addr   <= rd_addr;
      end
    end
  end

  // standby only when deselected and no internal operation running
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      standby <= 1'b1;
    end else begin
      standby <= !active && !op_busy && !prog_pend && !op_start;
    end
  end

  // output shifter: the byte is refetched until its first bit goes out
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      obyte              <= '0;
      dual               <= 1'b0;
      dual_lane_low_out  <= 1'b0;
      dual_lane_low_oe   <= 1'b0;
      dual_lane_high_out <= 1'b0;
      dual_lane_high_oe  <= 1'b0;
    end else if (!active || st != sfp_pkg::st_rd) begin
      dual_lane_low_oe  <= 1'b0;
      dual_lane_high_oe <= 1'b0;
      dual              <= (opc == sfp_pkg::op_read_dual);
      obyte             <= rd_data;
    end else if (fall) begin
      dual_lane_high_oe <= 1'b1;
      if (dual) begin
        dual_lane_low_oe   <= 1'b1;
        dual_lane_high_out <= obyte[7];
        dual_lane_low_out  <= obyte[6];
        obyte              <= {obyte[5:0], 2'b00};
      end else begin
        dual_lane_high_out <= obyte[7];
        obyte              <= {obyte[6:0], 1'b0};
      end
    end else if (obit == 3'h0) begin
      // the last address bit lands as the read state is entered, so fetch here
      obyte <= rd_data;
    end
  end

  // bit position within the byte on the lanes; the address does not advance
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      obit <= '0;
    end else if (!active || st != sfp_pkg::st_rd) begin
      obit <= '0;
    end else if (fall) begin
      obit <= obit + (dual ? 3'h2 : 3'h1);
    end
  end

  // sck_q kept for visibility of link idle level
  logic unused_sck;
  assign unused_sck = sck_q;
endmodule

// >>> shared/sfp_pkg.sv
// package of constants and types for the serial flash pin interface
package sfp_pkg;
  localparam int          byte_w        = 8;
  localparam int          addr_w        = 24;
  localparam int          fifo_depth    = 8;
  localparam int          page_bytes    = 256;
  localparam logic [7:0]  op_read       = 8'h03;
  localparam logic [7:0]  op_read_dual  = 8'h3b;
  localparam logic [7:0]  op_program    = 8'h02;
  localparam logic [7:0]  op_prog_dual  = 8'ha2;
  localparam logic [7:0]  op_erase      = 8'h20;
  localparam logic [4:0]  addr_bits     = 5'h18;
  localparam logic [2:0]  sync_rst      = 3'h7;
  localparam logic [8:0]  page_max      = 9'h100;

  typedef enum logic [2:0] {st_idle, st_cmd, st_addr, st_rd, st_wr, st_skip} sfp_state_type;
endpackage

// >>> shared/sfp_fifo_if.sv
// stream interface between the pin engine and the data fifo
`timescale 1ns/1ps
interface sfp_fifo_if #(parameter int width = 8);
  logic [width-1:0] wdata;
  logic             wvalid;
  logic             wready;
  logic [width-1:0] rdata;
  logic             rvalid;
  logic             rready;
  modport fifo (input wdata, input wvalid, output wready, output rdata, output rvalid, input rready);
  modport user (output wdata, output wvalid, input wready, input rdata, input rvalid, output rready);
endinterface

// >>> hdl/sfp_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sfp_fifo #(
  parameter int width = 8,
  parameter int depth = 8
) (
  // clock and reset
  input wire logic   clock,
  input wire logic   arst_n,
  // streams
  sfp_fifo_if.fifo   port
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw:0]      wr_ptr;
  logic [aw:0]      rd_ptr;
  logic [aw:0]      count;

  assign count      = wr_ptr - rd_ptr;
  assign port.wready = (count != depth[aw:0]);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
    end else if (port.wvalid && port.wready) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (port.wvalid && port.wready) begin
      mem[wr_ptr[aw-1:0]] <= port.wdata;
    end
  end

  // read data comes from a register so the consumer sees a stable word
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_ptr      <= '0;
      port.rvalid <= 1'b0;
      port.rdata  <= '0;
    end else if (!port.rvalid || port.rready) begin
      port.rvalid <= (count != '0);
      if (count != '0) begin
        port.rdata <= mem[rd_ptr[aw-1:0]];
        rd_ptr     <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// >>> dv/sfp_flash_pins_sva.sv
// port assertions for the flash pin block
`timescale 1ns/1ps
module sfp_flash_pins_sva (
  // watched ports
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        sel_n,
  input wire logic        sck,
  input wire logic        dual_lane_low_oe,
  input wire logic        dual_lane_high_out,
  input wire logic        dual_lane_high_oe,
  input wire logic [23:0] rd_addr,
  input wire logic [7:0]  wr_data,
  input wire logic        wr_valid,
  input wire logic        wr_ready,
  input wire logic        op_start,
  input wire logic        op_busy,
  input wire logic        standby
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_hi; sel_n [*5] |-> !dual_lane_high_oe; endproperty
  a_hi: assert property (p_hi) else $error("high lane on idle");
  property p_lo; sel_n [*5] |-> !dual_lane_low_oe; endproperty
  a_lo: assert property (p_lo) else $error("low lane on idle");
  property p_addr; sel_n [*6] |=> $stable(rd_addr); endproperty
  a_addr: assert property (p_addr) else $error("addr moved idle");
  // output stage follows the synced falling edge, so sck was low a few cycles back
  property p_fall; dual_lane_high_oe && $changed(dual_lane_high_out)
    |-> !$past(sck, 2) || !$past(sck, 3) || !$past(sck, 4); endproperty
  a_fall: assert property (p_fall) else $error("lane moved off fall");
  property p_pair; dual_lane_low_oe |-> dual_lane_high_oe; endproperty
  a_pair: assert property (p_pair) else $error("low lane alone");
  property p_hold; wr_valid && !wr_ready |=> wr_valid && $stable(wr_data); endproperty
  a_hold: assert property (p_hold) else $error("stream dropped");
  property p_start; op_start |-> sel_n && $past(sel_n, 2); endproperty
  a_start: assert property (p_start) else $error("start while selected");
  property p_busy; op_busy [*2] |-> !standby; endproperty
  a_busy: assert property (p_busy) else $error("standby while busy");
  c_dual: cover property (dual_lane_low_oe);
  c_flow: cover property (wr_valid && wr_ready);
  c_start: cover property (op_start);
endmodule
bind sfp_flash_pins sfp_flash_pins_sva sfp_flash_pins_sva_i (.*);

// >>> dv/sfp_host.sv
// link host model driving select, clock and input lane
`timescale 1ns/1ps
module sfp_host (
  // to the target
  output logic      sel_n,
  output logic      sck,
  output logic      dual_lane_low_in,
  // from the target
  input  wire logic dual_lane_low_out,
  input  wire logic dual_lane_low_oe,
  input  wire logic dual_lane_high_out
);
  logic d = 1'b1;
  logic drive = 1'b1;
  logic idle_hi = 1'b0;
  int   pause = 0;
  initial sel_n = 1'b1;
  initial sck = 1'b0;
  // no pull on the lane: released, it shows the inverse of its last level
  assign dual_lane_low_in = dual_lane_low_oe ? dual_lane_low_out : (drive ? d : ~d);
  task automatic put_byte(input logic [7:0] b);
    #(pause);
    drive = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      d = b[i];
      #80 sck = 1'b1;
      #80;
    end
  endtask
  task automatic start(input logic mode3, input logic [7:0] op, input logic [23:0] a);
    idle_hi = mode3;
    sck = mode3;
    #80 sel_n = 1'b0;
    #80 put_byte(op);
    for (int k = 2; k >= 0; k--) put_byte(a[k*8 +: 8]);
  endtask
  task automatic stop();
    #80 sck = idle_hi;
    #80 sel_n = 1'b1;
    #160;
  endtask
  task automatic get_byte(input logic dual, output logic [7:0] b);
    drive = !dual;
    for (int i = 7; i >= 0; i = i - (dual ? 2 : 1)) begin
      sck = 1'b0;
      #80 sck = 1'b1;
      b[i] = dual_lane_high_out;
      if (dual) b[i-1] = dual_lane_low_in;
      #80;
    end
  endtask
endmodule

// >>> dv/testbench.sv
// self-checking bench for the flash pin block
`timescale 1ns/1ps
module testbench;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        sel_n, sck, dual_lane_low_in, dual_lane_low_out, dual_lane_low_oe, dual_lane_high_out;
  logic        dual_lane_high_oe, wr_valid, wr_ready, op_start, op_busy, standby;
  logic [7:0]  rd_data, wr_data, op_code, b;
  logic [23:0] rd_addr, wr_addr;
  logic [7:0]  got[$];
  int          n_fail = 0, checks = 0, cycles = 0, busy = 0, starts = 0;
  sfp_flash_pins sfp_flash_pins_i (.*);
  sfp_host sfp_host_i (.*);
  always #10 clock = ~clock;
  assign rd_data = rd_addr[7:0] ^ 8'h5a;
  assign op_busy = busy != 0;
  always @(posedge clock) begin
    cycles++;
    if (op_start === 1'b1) starts++;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) got.push_back(wr_data);
    busy <= (op_start === 1'b1) ? 30 : (busy > 0 ? busy - 1 : 0);
    if (cycles == 40000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_idle();
    logic [23:0] a;
    a = rd_addr;
    sfp_host_i.put_byte(8'h03);
    sfp_host_i.put_byte(8'hc6);
    check(rd_addr, a);
    check(24'({dual_lane_high_oe, standby}), 24'h1);
    $display("idle test done");
  endtask
  task automatic t_read(input logic mode3, input logic dual, input logic [23:0] a);
    sfp_host_i.start(mode3, dual ? sfp_pkg::op_read_dual : sfp_pkg::op_read, a);
    sfp_host_i.get_byte(dual, b);
    check(rd_addr, a);
    check(24'(b), 24'(a[7:0] ^ 8'h5a));
    sfp_host_i.stop();
    check(24'({dual_lane_high_oe, dual_lane_low_oe}), 24'h0);
    $display("read test done");
  endtask
  task automatic t_prog(input logic [7:0] op, input int n, input logic stall);
    int s;
    s = starts;
    got.delete();
    @(posedge clock) #1 wr_ready = !stall;
    // slow host while the sink stalls
    sfp_host_i.pause = stall ? 400 : 0;
    sfp_host_i.start(1'b0, op, 24'h424140);
    for (int i = 0; i < n; i++) sfp_host_i.put_byte(8'(i) ^ 8'hc3);
    sfp_host_i.stop();
    check(24'(starts - s), 24'h1);
    check(wr_addr, 24'h424140);
    check(24'({op_code, standby}), 24'({op, 1'b0}));
    @(posedge clock) #1 wr_ready = 1'b1;
    repeat (40) @(posedge clock);
    check(24'(got.size()), 24'(n > sfp_pkg::page_bytes ? sfp_pkg::page_bytes : n));
    foreach (got[i]) check(24'(got[i]), 24'(8'(i) ^ 8'hc3));
    check(24'(standby), 24'h1);
    $display("program test done");
  endtask
  initial begin
    wr_ready = 1'b1;
    repeat (2) @(posedge clock);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    t_idle();
    for (int m = 0; m < 4; m++) t_read(m[1], m[0], 24'h12a5c0 + 24'(m));
    t_prog(sfp_pkg::op_program, 8, 1'b1);
    t_prog(sfp_pkg::op_prog_dual, 257, 1'b0);
    t_prog(sfp_pkg::op_erase, 0, 1'b0);
    complete_run();
  end
endmodule
